// ==== common/pdl_pkg.sv ====
// constants for the port data latch bank: map, masks and reset values
package pdl_pkg;

  localparam int NPORT = 12; // number of port data registers
  localparam int PW = 8; // bits per port register
  localparam int ADDR_W = 18; // avalon byte address width
  localparam int DATA_W = 32; // avalon data width

  // register index of each port; byte address is four times the index
  localparam logic [15:0] PORT_1_LATCH = 16'hff01;
  localparam logic [15:0] PORT_2_LATCH = 16'hff02;
  localparam logic [15:0] PORT_3_LATCH = 16'hff03;
  localparam logic [15:0] PORT_4_LATCH = 16'hff04;
  localparam logic [15:0] PORT_8_LATCH = 16'hff08;
  localparam logic [15:0] PORT_9_LATCH = 16'hff09;
  localparam logic [15:0] PORT_10_LATCH = 16'hff0a;
  localparam logic [15:0] PORT_11_LATCH = 16'hff0b;
  localparam logic [15:0] PORT_12_LATCH = 16'hff0c;
  localparam logic [15:0] PORT_13_LATCH = 16'hff0d;
  localparam logic [15:0] PORT_14_LATCH = 16'hff0e;
  localparam logic [15:0] PORT_15_LATCH = 16'hff0f;

  // table order: slot k of every per-port array belongs to this register
  localparam logic [15:0] PORT_INDEX [NPORT] = '{
    PORT_1_LATCH, PORT_2_LATCH, PORT_3_LATCH, PORT_4_LATCH,
    PORT_8_LATCH, PORT_9_LATCH, PORT_10_LATCH, PORT_11_LATCH,
    PORT_12_LATCH, PORT_13_LATCH, PORT_14_LATCH, PORT_15_LATCH};

  // slots of the ports with special bits
  localparam int SLOT_PORT_12 = 8;
  localparam int SLOT_PORT_14 = 10;
  localparam int SLOT_PORT_15 = 11;

  // bits that exist; the rest are fixed zero
  localparam logic [7:0] PORT_VALID [NPORT] = '{
    8'hff, 8'hff, 8'h1f, 8'hff, 8'h0f, 8'h0f,
    8'h0f, 8'h0f, 8'h1f, 8'h0f, 8'hff, 8'hff};

  localparam logic [7:0] PORT_12_RO_MASK = 8'h1e; // input-only bits 1..4
  localparam logic [7:0] KEY_SCAN_MASK = 8'hf0; // key scan nibble of ports 14, 15
  localparam int KEY_LSB = 4; // lowest key scan bit position
  localparam logic [7:0] LATCH_RESET = 8'h00; // output latch after reset

endpackage : pdl_pkg

// ==== design/pdl_port_bank.sv ====
// port data latch bank with avalon-mm register access
//
// Summary of operation
// - in output mode the pin drives the latched bit, 0 low and 1 high.
// - in input mode a read returns the pin level, 0 low and 1 high.
// - bits 1 to 4 of port 12 are read-only; writes there change nothing.
// - those port 12 input-only bits are undefined after reset, not zero.
// - a bit whose pin is in clock input mode always reads 0.
// - upper nibbles of ports 14 and 15 serve the display key scan function.
//
// The Avalon-MM interface to the registers is this design's own decision.
`timescale 1ns/1ps
module pdl_port_bank #(
  parameter int NPORT = pdl_pkg::NPORT,
  parameter int PW = pdl_pkg::PW
) (
  input wire logic clk_sys, // system clock, 25 MHz
  input wire logic rst, // asynchronous reset, active high
  input wire logic [pdl_pkg::ADDR_W-1:0] avs_address, // byte address
  input wire logic avs_read, // read request
  input wire logic avs_write, // write request
  input wire logic [pdl_pkg::DATA_W-1:0] avs_writedata, // write data, low byte used
  input wire logic [3:0] avs_byteenable, // byte lanes; lane 0 holds the port
  output logic [pdl_pkg::DATA_W-1:0] avs_readdata, // read data
  output logic avs_waitrequest, // high until the access is answered
  input wire logic [NPORT-1:0][PW-1:0] pin_in, // pin levels, asynchronous
  input wire logic [NPORT-1:0][PW-1:0] out_mode, // 1: bit is an output
  input wire logic [NPORT-1:0][PW-1:0] clk_in_mode, // 1: pin is a clock input
  output logic [NPORT-1:0][PW-1:0] pin_out, // level driven on each pin
  output logic [NPORT-1:0][PW-1:0] pin_oe, // 1: pin is driven
  output logic [3:0] key_scan_a, // key scan bits a0..a3 from port 14
  output logic [3:0] key_scan_b // key scan bits b0..b3 from port 15
);

  typedef struct packed {
    logic [NPORT-1:0][PW-1:0] latch;
    logic [NPORT-1:0][PW-1:0] drv;
    logic [NPORT-1:0][PW-1:0] oe;
    logic [3:0] key_a;
    logic [3:0] key_b;
    logic [pdl_pkg::DATA_W-1:0] rdata;
    logic wait_req;
  } pdl_state_t;

  pdl_state_t st;
  pdl_state_t next_st;
  logic [NPORT-1:0][PW-1:0] pin_sync;
  logic hit;
  logic [3:0] slot;
  logic req;

  // pins pass two flops before anything reads them
  pdl_sync #(
    .W(NPORT * PW)
  ) u_sync (
    .clk_sys(clk_sys),
    .d_async(pin_in),
    .q_sync(pin_sync)
  );

  // key scan positions per slot; they never reach a pin
  function automatic logic [7:0] key_mask(input int k);
    if (k == pdl_pkg::SLOT_PORT_14 || k == pdl_pkg::SLOT_PORT_15) begin
      return pdl_pkg::KEY_SCAN_MASK;
    end
    return 8'h00;
  endfunction : key_mask

  // read-only positions per slot
  function automatic logic [7:0] ro_mask(input int k);
    if (k == pdl_pkg::SLOT_PORT_12) begin
      return pdl_pkg::PORT_12_RO_MASK;
    end
    return 8'h00;
  endfunction : ro_mask

  // value that a read of slot k returns
  function automatic logic [7:0] port_value(input int k);
    logic [7:0] v;
    logic [7:0] ro;
    logic [7:0] km;
    v = 8'h00;
    ro = ro_mask(k);
    km = key_mask(k);
    for (int b = 0; b < PW; b++) begin
      if (ro[b]) begin
        v[b] = pin_sync[k][b]; // undefined until first sampled
      end else if (km[b] || out_mode[k][b]) begin
        v[b] = st.latch[k][b];
      end else begin
        v[b] = pin_sync[k][b]; // input mode returns the pin level
      end
      if (clk_in_mode[k][b]) begin
        v[b] = 1'b0; // clock input pins read zero
      end
    end
    return v & pdl_pkg::PORT_VALID[k]; // fixed zero bits
  endfunction : port_value

  // address decode: aligned word at four times a port index
  always_comb begin
    hit = 1'b0;
    slot = 4'h0;
    for (int k = 0; k < NPORT; k++) begin
      if (avs_address == {pdl_pkg::PORT_INDEX[k], 2'b00}) begin
        hit = 1'b1;
        slot = 4'(k);
      end
    end
  end

  assign req = avs_read | avs_write;

  // next state: bus handshake, register writes and pin drive
  always_comb begin
    logic [7:0] wmask;
    logic [7:0] wbyte;
    wmask = 8'h00;
    wbyte = avs_writedata[7:0];
    next_st = st;
    // waitrequest drops one cycle after a request, then rises again
    next_st.wait_req = !(req && st.wait_req);
    if (req && st.wait_req) begin
      next_st.rdata = '0;
      if (avs_read && hit) begin
        next_st.rdata[7:0] = port_value(int'(slot));
      end
    end
    // write lands at the edge where waitrequest is seen low
    if (avs_write && !st.wait_req && hit && avs_byteenable[0]) begin
      wmask = pdl_pkg::PORT_VALID[slot] & ~ro_mask(int'(slot));
      next_st.latch[slot] = (st.latch[slot] & ~wmask) | (wbyte & wmask);
    end
    // pin drive from the latch; key scan bits go to the display side
    for (int k = 0; k < NPORT; k++) begin
      next_st.drv[k] = st.latch[k]; // 0 drives low, 1 drives high
      next_st.oe[k] = out_mode[k] & pdl_pkg::PORT_VALID[k] & ~ro_mask(k)
        & ~key_mask(k);
    end
    next_st.key_a = st.latch[pdl_pkg::SLOT_PORT_14][pdl_pkg::KEY_LSB +: 4];
    next_st.key_b = st.latch[pdl_pkg::SLOT_PORT_15][pdl_pkg::KEY_LSB +: 4];
  end

  // state register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st.latch <= {NPORT{pdl_pkg::LATCH_RESET}};
      st.drv <= '0;
      st.oe <= '0;
      st.key_a <= 4'h0;
      st.key_b <= 4'h0;
      st.rdata <= '0;
      st.wait_req <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from flops
  assign avs_readdata = st.rdata;
  assign avs_waitrequest = st.wait_req;
  assign pin_out = st.drv;
  assign pin_oe = st.oe;
  assign key_scan_a = st.key_a;
  assign key_scan_b = st.key_b;

endmodule : pdl_port_bank

// ==== design/pdl_sync.sv ====
// two-stage synchroniser bank for the pin levels
`timescale 1ns/1ps
module pdl_sync #(
  parameter int W = 8
) (
  input wire logic clk_sys, // system clock
  input wire logic [W-1:0] d_async, // levels from the pins
  output logic [W-1:0] q_sync // levels after two flops
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } pdl_sync_t;

  pdl_sync_t st;
  pdl_sync_t next_st;

  // shift chain; no reset so input-only bits stay undefined until sampled
  always_comb begin
    next_st = st;
    next_st.s1 = d_async;
    next_st.s2 = st.s1; // first stage feeds only the second
  end

  always_ff @(posedge clk_sys) begin
    st <= next_st;
  end

  assign q_sync = st.s2;

endmodule : pdl_sync

// ==== dv/pdl_pins.sv ====
// pin model: driven pins show the latch level, released pins the outside level
`timescale 1ns/1ps
module pdl_pins (
  input wire logic [pdl_pkg::NPORT-1:0][7:0] pin_out, // levels from the bank
  input wire logic [pdl_pkg::NPORT-1:0][7:0] pin_oe, // drive enables from the bank
  input wire logic [pdl_pkg::NPORT-1:0][7:0] ext, // level forced by the outside world
  output logic [pdl_pkg::NPORT-1:0][7:0] pin_in // resolved pin levels
);
  // a driven pin carries the driven level, otherwise the outside level
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext);
endmodule : pdl_pins

// ==== dv/pdl_port_bank_chk.sv ====
// port-level assertions for the port data latch bank
`timescale 1ns/1ps
module pdl_port_bank_chk #(
  parameter int NPORT = 12,
  parameter int PW = 8
) (
  input wire logic clk_sys, // clock
  input wire logic rst, // reset
  input wire logic avs_read, // read request
  input wire logic avs_write, // write request
  input wire logic [31:0] avs_readdata, // read data
  input wire logic avs_waitrequest, // wait
  input wire logic [NPORT-1:0][PW-1:0] out_mode, // output mode
  input wire logic [NPORT-1:0][PW-1:0] clk_in_mode, // clock input mode
  input wire logic [NPORT-1:0][PW-1:0] pin_oe, // drive enables
  input wire logic [3:0] key_scan_a // key scan a
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // pins drive only in output mode, and never on read-only bits, key bits or the absent bits of port 8
  drive_mode_a: assert property ((pin_oe & ~$past(out_mode)) == '0)
    else $error("pin driven outside output mode");
  ro_drive_a: assert property (pin_oe[8][4:1] == 4'h0)
    else $error("input-only bit driven");
  key_drive_a: assert property ((pin_oe[10][7:4] | pin_oe[11][7:4]) == 4'h0)
    else $error("key scan bit driven");
  fixed_drive_a: assert property (pin_oe[4][7:4] == 4'h0)
    else $error("absent bit driven");
  // read answers: one-cycle answer, clock input reads zero, upper bytes zero
  wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("answer held too long");
  clk_read_a: assert property (!avs_waitrequest && $past(avs_read) && &$past(clk_in_mode)
    |-> avs_readdata == 32'h0) else $error("clock input bit read nonzero");
  fixed_read_a: assert property (avs_readdata[31:8] == 24'h0)
    else $error("fixed bits read nonzero");
  cover property (!avs_waitrequest && $past(avs_write));
  cover property (!avs_waitrequest && &$past(clk_in_mode));
  cover property (key_scan_a == 4'hf);
endmodule : pdl_port_bank_chk
bind pdl_port_bank pdl_port_bank_chk #(.NPORT(NPORT), .PW(PW)) chk_i (.*);

// ==== dv/pdl_port_bank_tb.sv ====
// self-checking bench for the port data latch bank
`timescale 1ns/1ps
module pdl_port_bank_tb;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [17:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [11:0][7:0] pin_in, pin_out, pin_oe, out_mode = '0, clk_in_mode = '0, ext = '0;
  logic [3:0] key_scan_a, key_scan_b;
  logic [7:0] q, m;
  int n_mismatch = 0;
  int check_count = 0;
  pdl_port_bank pdl_port_bank_i (.*);
  pdl_pins pdl_pins_i (.pin_out(pin_out), .pin_oe(pin_oe), .ext(ext), .pin_in(pin_in));
  always #20 clk_sys = ~clk_sys;
  // one avalon access; holds the request until waitrequest is seen low
  task automatic bus(input logic wr, input logic [17:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_read <= !wr;
    avs_write <= wr;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    q = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // read value: latch where output mode or key bit, pin where input or read-only
  function automatic logic [7:0] ex(int k, logic [7:0] lat, logic [7:0] pin, logic om);
    logic [7:0] s;
    s = om ? 8'hff : 8'h00;
    if (k == pdl_pkg::SLOT_PORT_14 || k == pdl_pkg::SLOT_PORT_15) s |= pdl_pkg::KEY_SCAN_MASK;
    if (k == pdl_pkg::SLOT_PORT_12) s &= ~pdl_pkg::PORT_12_RO_MASK;
    return ((lat & s) | (pin & ~s)) & pdl_pkg::PORT_VALID[k];
  endfunction : ex
  function automatic logic [17:0] ad(int k);
    return {pdl_pkg::PORT_INDEX[k], 2'b00};
  endfunction : ad
  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : complete_run
  // watchdog against a hung handshake
  initial begin
    repeat (5000) @(posedge clk_sys);
    n_mismatch++;
    complete_run;
  end
  // main sequence
  initial begin
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    out_mode <= '1;
    ext <= {12{8'h5a}};
    repeat (4) @(posedge clk_sys);
    for (int k = 0; k < 12; k++) begin
      bus(1'b0, ad(k), 8'h00);
      chk(q, ex(k, 8'h00, 8'h5a, 1'b1));
      bus(1'b1, ad(k), 8'hff);
      bus(1'b0, ad(k), 8'h00);
      chk(q, ex(k, 8'hff, 8'h5a, 1'b1));
      repeat (2) @(posedge clk_sys);
      m = (k >= 10) ? 8'h0f : 8'hff;
      chk(pin_out[k] & pin_oe[k], ex(k, 8'hff, 8'h00, 1'b1) & m);
    end
    chk({key_scan_a, key_scan_b}, 8'hff);
    bus(1'b0, 18'h0, 8'h00);
    chk(q, 8'h00);
    out_mode <= '0;
    ext <= {12{8'ha5}};
    repeat (4) @(posedge clk_sys);
    for (int k = 0; k < 12; k++) begin
      bus(1'b0, ad(k), 8'h00);
      chk(q, ex(k, 8'hff, 8'ha5, 1'b0));
    end
    out_mode <= '1;
    ext <= '0;
    bus(1'b1, ad(pdl_pkg::SLOT_PORT_12), 8'h1f);
    repeat (4) @(posedge clk_sys);
    bus(1'b0, ad(pdl_pkg::SLOT_PORT_12), 8'h00);
    chk(q, 8'h01);
    chk(pin_out[pdl_pkg::SLOT_PORT_12], 8'h01);
    // a write with lane 0 disabled leaves the latch alone
    avs_byteenable <= 4'he;
    bus(1'b1, ad(pdl_pkg::SLOT_PORT_14), 8'h00);
    avs_byteenable <= 4'hf;
    bus(1'b1, ad(pdl_pkg::SLOT_PORT_15), 8'h3c);
    bus(1'b0, ad(pdl_pkg::SLOT_PORT_14), 8'h00);
    chk(q, 8'hff);
    bus(1'b0, ad(pdl_pkg::SLOT_PORT_15), 8'h00);
    chk(q, 8'h3c);
    chk({key_scan_a, key_scan_b}, 8'hf3);
    clk_in_mode <= '1;
    for (int k = 0; k < 12; k++) begin
      bus(1'b0, ad(k), 8'h00);
      chk(q, 8'h00);
    end
    clk_in_mode <= '0;
    // reset in mid-run clears the latches and the key scan outputs
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    bus(1'b0, ad(1), 8'h00);
    chk(q, 8'h00);
    chk(pin_out[1], 8'h00);
    chk({key_scan_a, key_scan_b}, 8'h00);
    complete_run;
  end
endmodule : pdl_port_bank_tb
